/* logic/scr_pkg.sv */
package scr_pkg;

  // Register addresses (7-bit frame address field)
  localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] ADDR_HW_CONTROL  = 7'h02;
  localparam logic [6:0] ADDR_WD_CONTROL  = 7'h03;

  // Power-on / soft reset values
  localparam logic [7:0] RST_MODE_SUPPLY  = 8'h00;
  localparam logic [7:0] RST_HW_CONTROL   = 8'h00;
  localparam logic [7:0] RST_WD_CONTROL   = 8'h14;

  // Restart: bits in KEEP hold their content, the rest take RESTART value
  localparam logic [7:0] KEEP_MODE_SUPPLY = 8'h07;
  localparam logic [7:0] KEEP_HW_CONTROL  = 8'hdf;
  localparam logic [7:0] KEEP_WD_CONTROL  = 8'h98;
  localparam logic [7:0] RSTRT_MODE_SUP   = 8'h00;
  localparam logic [7:0] RSTRT_HW_CONTROL = 8'h00;
  localparam logic [7:0] RSTRT_WD_CONTROL = 8'h04;

  // Writable mask of mode/supply register (bit 5 reserved)
  localparam logic [7:0] WMASK_MODE_SUP   = 8'hdf;

  // Field positions, mode/supply register
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int SUP2_HI = 4;
  localparam int SUP2_LO = 3;
  localparam int OVRST   = 2;
  localparam int RT_HI   = 1;
  localparam int RT_LO   = 0;
  // Field positions, hardware control register
  localparam int HW_FS_DIS   = 7;
  localparam int HW_LAG      = 6;
  localparam int HW_FO_FORCE = 5;
  localparam int HW_BY_WAKE  = 4;
  localparam int HW_AUTO     = 3;
  localparam int HW_BST_V    = 2;
  localparam int HW_BST_EN   = 1;
  localparam int HW_CFG      = 0;
  // Field positions, watchdog control register
  localparam int WD_STOP_DIS = 6;
  localparam int WD_WINDOW   = 5;
  localparam int WD_BUS_WAKE = 4;
  localparam int WD_MAX3     = 3;
  localparam int WD_PER_HI   = 2;
  localparam int WD_PER_LO   = 0;

  // Frame and timing
  localparam int FRAME_BITS   = 16;
  localparam int CLK_MHZ      = 200;
  localparam int LAG_SHORT_NS = 100000;
  localparam int LAG_LONG_NS  = 1000000;
  localparam int LAG_SHORT_CYC = LAG_SHORT_NS * CLK_MHZ / 1000;
  localparam int LAG_LONG_CYC  = LAG_LONG_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP  = 2'b01,
    MODE_STOP   = 2'b10,
    MODE_SOFT   = 2'b11
  } scr_mode_e;

  // Frame bits 15:8 data, bit 7 access, bits 6:0 address
  typedef struct packed {
    logic [7:0] data;
    logic       write;
    logic [6:0] addr;
  } scr_frame_s;

endpackage

/* logic/scr_spi_control_registers.sv */
`timescale 1ns/1ps
// Behaviour
// - Reset loads reset values; restart loads restart values keeping marked bits.
// - A frame is sixteen bits: address with access bit, then data byte.
// - Data bits D0..D7 sit at frame bits 8..15.
// - Frame bit 7 low reads, high writes the data byte.
// - Reserved bits read zero; rw bits host writable; rwh also hardware.
// - Control bits change only by host writes, except hardware-updated ones.
// - Mode field 00 normal, 01 sleep, 10 stop, 11 soft reset without reset pin.
// - Second supply on per field: off, normal, normal+stop, all three modes.
// - Overvoltage reset enable makes main overvoltage force a restart with reset.
// - Threshold field picks one of three levels; 11 disables undervoltage reset.
// - Sleep request with no wake source gives restart and reset instead.
// - Fail-safe disable bit turns the input pin into second fail output.
// - Lag bit picks 100 us or 1 ms before buck returns to PFM.
// - Force bit activates fail outputs; otherwise only a failure does.
// - In stop with wake-pin bit set the wake pin level selects PWM.
// - Auto bit lets large load force PWM in stop until stop is rewritten.
// - Boost voltage select bit and boost enable gated by low battery.
// - Fail outputs trip after second, or with config bit first, watchdog failure.
// - Watchdog write with odd data parity is ignored and flags serial failure.
// - Watchdog stop-disable bit halts the watchdog in stop mode.
// - Watchdog type bit selects time-out or window operation.
// - Bus-wake bit lets a transceiver wake in stop start the watchdog.
module scr_spi_control_registers #(
  parameter int unsigned LAG_SHORT = scr_pkg::LAG_SHORT_CYC,
  parameter int unsigned LAG_LONG  = scr_pkg::LAG_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       csn_n,
  input  wire logic       mosi,
  output logic            miso_o,
  output logic            miso_oe,
  input  wire logic       wake_pin,
  input  wire logic       wake_source_any,
  input  wire logic       overvoltage_evt,
  input  wire logic       restart_req,
  input  wire logic       bus_wake_evt,
  input  wire logic       large_load,
  input  wire logic       battery_low,
  input  wire logic       wd_fail_evt,
  input  wire logic       spi_fail_clr,
  output logic [1:0]      chip_mode,
  output logic            second_supply_on,
  output logic            main_supply_overvoltage_reset_en,
  output logic [1:0]      main_supply_reset_threshold,
  output logic            failsafe_input_disable,
  output logic            fail_outputs,
  output logic            second_fail_output,
  output logic            buck_pwm,
  output logic            boost_on,
  output logic            boost_v_low,
  output logic            wd_enable,
  output logic            wd_window_mode,
  output logic            wd_long_window,
  output logic [2:0]      wd_period,
  output logic            wd_max3_reset,
  output logic            reset_out,
  output logic            spi_fail
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: sclk, frame held while csn_n high

  typedef struct packed {
    logic [15:0] sh;
    logic [3:0]  cnt;
  } scr_shift_s;

  typedef struct packed {
    scr_pkg::scr_frame_s frame;
    logic                tog;
  } scr_link_s;

  scr_shift_s sh_r, sh_nxt;
  scr_link_s  lk_r, lk_nxt;
  logic       link_rst_n;
  logic       miso_r, miso_oe_r;
  logic [15:0] resp_w;

  // Frame framing ends with csn_n, so the counter is reset by it
  assign link_rst_n = rstn & ~csn_n;

  always_comb begin
    sh_nxt = sh_r;
    lk_nxt = lk_r;
    sh_nxt.sh  = {mosi, sh_r.sh[15:1]};  // LSB first
    sh_nxt.cnt = sh_r.cnt + 4'h1;
    if (sh_r.cnt == 4'hf) begin
      lk_nxt.frame = scr_pkg::scr_frame_s'({mosi, sh_r.sh[15:1]});
      lk_nxt.tog   = ~lk_r.tog;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // Response word is quasi-static: updated only after a frame is handled
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_r    <= resp_w[4'(sh_r.cnt - 4'h1)];
      miso_oe_r <= 1'b1;
    end
  end

  assign miso_o  = miso_r;
  assign miso_oe = miso_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain

  typedef struct packed {
    logic [2:0]  tsync;
    logic [2:0]  wsync;
    logic        wake_lvl;
    logic [7:0]  ms;
    logic [7:0]  hw;
    logic [7:0]  wd;
    logic [15:0] resp;
    logic        auto_pwm;
    logic        bus_started;
    logic [17:0] lag;
    logic [1:0]  wdf;
    logic        fail_latch;
    logic [1:0]  mode_o;
    logic        sup2_o;
    logic        fail_o;
    logic        fail2_o;
    logic        pwm_o;
    logic        boost_o;
    logic        wd_en_o;
    logic        long_win_o;
    logic        rst_o;
    logic        spi_fail_o;
  } scr_core_s;

  scr_core_s           st_r, st_nxt;
  scr_pkg::scr_frame_s f;
  logic                ev;
  scr_pkg::scr_mode_e  cur_mode;
  logic                demand;
  logic [17:0]         lag_lim;

  assign f        = lk_r.frame;
  // Stage 1 feeds only stage 2; event counted on stage 2/3 mismatch
  assign ev       = st_r.tsync[1] ^ st_r.tsync[2];
  assign cur_mode = scr_pkg::scr_mode_e'(st_r.ms[scr_pkg::MODE_HI:scr_pkg::MODE_LO]);
  assign resp_w   = st_r.resp;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tsync = {st_r.tsync[1:0], lk_r.tog};
    st_nxt.wsync = {st_r.wsync[1:0], wake_pin};
    if (st_r.wsync[1] == st_r.wsync[2]) begin
      st_nxt.wake_lvl = st_r.wsync[2];
    end
    st_nxt.rst_o      = 1'b0;
    st_nxt.long_win_o = 1'b0;
    demand  = 1'b0;
    lag_lim = 18'(LAG_SHORT - 1);

    // Host frame; set of the fail flag beats its clear
    if (spi_fail_clr) begin
      st_nxt.spi_fail_o = 1'b0;
    end
    if (ev && f.write) begin
      if (f.addr == scr_pkg::ADDR_MODE_SUPPLY) begin
        st_nxt.ms = f.data & scr_pkg::WMASK_MODE_SUP;
        if (f.data[scr_pkg::MODE_HI:scr_pkg::MODE_LO] == scr_pkg::MODE_STOP) begin
          st_nxt.auto_pwm = 1'b0;
        end
      end else if (f.addr == scr_pkg::ADDR_HW_CONTROL) begin
        st_nxt.hw = f.data;
      end else if (f.addr == scr_pkg::ADDR_WD_CONTROL) begin
        if (^f.data) begin
          st_nxt.spi_fail_o = 1'b1;
        end else begin
          st_nxt.wd = f.data;
        end
      end
    end
    if (ev) begin
      st_nxt.resp[7:0] = 8'h00;
      if (f.addr == scr_pkg::ADDR_MODE_SUPPLY) begin
        st_nxt.resp[15:8] = st_r.ms;
      end else if (f.addr == scr_pkg::ADDR_HW_CONTROL) begin
        st_nxt.resp[15:8] = st_r.hw;
      end else if (f.addr == scr_pkg::ADDR_WD_CONTROL) begin
        st_nxt.resp[15:8] = st_r.wd;
      end else begin
        st_nxt.resp[15:8] = 8'h00;
      end
    end

    // Restart sources, then soft reset with the higher priority
    if ((overvoltage_evt && st_r.ms[scr_pkg::OVRST])
        || restart_req
        || (ev && f.write && f.addr == scr_pkg::ADDR_MODE_SUPPLY
            && f.data[scr_pkg::MODE_HI:scr_pkg::MODE_LO] == scr_pkg::MODE_SLEEP
            && !wake_source_any)) begin
      st_nxt.ms = (st_r.ms & scr_pkg::KEEP_MODE_SUPPLY) | scr_pkg::RSTRT_MODE_SUP;
      st_nxt.hw = (st_r.hw & scr_pkg::KEEP_HW_CONTROL) | scr_pkg::RSTRT_HW_CONTROL;
      st_nxt.wd = (st_r.wd & scr_pkg::KEEP_WD_CONTROL) | scr_pkg::RSTRT_WD_CONTROL;
      st_nxt.rst_o = 1'b1;
      st_nxt.auto_pwm    = 1'b0;
      st_nxt.bus_started = 1'b0;
    end
    if (ev && f.write && f.addr == scr_pkg::ADDR_MODE_SUPPLY
        && f.data[scr_pkg::MODE_HI:scr_pkg::MODE_LO] == scr_pkg::MODE_SOFT) begin
      // Soft reset: no pulse on the reset pin
      st_nxt.ms = scr_pkg::RST_MODE_SUPPLY;
      st_nxt.hw = scr_pkg::RST_HW_CONTROL;
      st_nxt.wd = scr_pkg::RST_WD_CONTROL;
      st_nxt.rst_o       = 1'b0;
      st_nxt.auto_pwm    = 1'b0;
      st_nxt.bus_started = 1'b0;
      st_nxt.wdf         = 2'h0;
      st_nxt.fail_latch  = 1'b0;
    end

    // Second supply
    st_nxt.mode_o = cur_mode;
    case (st_r.ms[scr_pkg::SUP2_HI:scr_pkg::SUP2_LO])
      2'b00:   st_nxt.sup2_o = 1'b0;
      2'b01:   st_nxt.sup2_o = (cur_mode == scr_pkg::MODE_NORMAL);
      2'b10:   st_nxt.sup2_o = (cur_mode == scr_pkg::MODE_NORMAL)
                               || (cur_mode == scr_pkg::MODE_STOP);
      default: st_nxt.sup2_o = (cur_mode != scr_pkg::MODE_SOFT);
    endcase

    // Fail outputs
    if (wd_fail_evt && st_r.wdf != 2'h3) begin
      st_nxt.wdf = st_r.wdf + 2'h1;
    end
    if (wd_fail_evt && (st_r.hw[scr_pkg::HW_CFG] || st_r.wdf != 2'h0)) begin
      st_nxt.fail_latch = 1'b1;
    end
    st_nxt.fail_o = st_r.hw[scr_pkg::HW_FO_FORCE] || st_r.fail_latch;
    st_nxt.fail2_o = st_r.hw[scr_pkg::HW_FS_DIS]
                     && (st_r.hw[scr_pkg::HW_FO_FORCE] || st_r.fail_latch);

    // Buck PWM/PFM with lag before falling back to PFM
    if (cur_mode == scr_pkg::MODE_STOP && st_r.hw[scr_pkg::HW_AUTO] && large_load) begin
      st_nxt.auto_pwm = 1'b1;
    end
    if (cur_mode == scr_pkg::MODE_STOP) begin
      demand = (st_r.hw[scr_pkg::HW_BY_WAKE] && st_r.wake_lvl)
               || st_r.auto_pwm;
    end else begin
      demand = (cur_mode == scr_pkg::MODE_NORMAL);
    end
    if (st_r.hw[scr_pkg::HW_LAG]) begin
      lag_lim = 18'(LAG_LONG - 1);
    end
    if (demand) begin
      st_nxt.pwm_o = 1'b1;
      st_nxt.lag   = 18'h0;
    end else if (st_r.pwm_o) begin
      st_nxt.lag = st_r.lag + 18'h1;
      if (st_r.lag >= lag_lim) begin
        st_nxt.pwm_o = 1'b0;
        st_nxt.lag   = 18'h0;
      end
    end

    st_nxt.boost_o = st_r.hw[scr_pkg::HW_BST_EN] && battery_low;

    // Watchdog run state
    if (cur_mode != scr_pkg::MODE_STOP) begin
      st_nxt.bus_started = 1'b0;
    end else if (bus_wake_evt && st_r.wd[scr_pkg::WD_BUS_WAKE] && !st_r.bus_started) begin
      st_nxt.bus_started = 1'b1;
      st_nxt.long_win_o  = 1'b1;
    end
    case (cur_mode)
      scr_pkg::MODE_NORMAL: st_nxt.wd_en_o = 1'b1;
      scr_pkg::MODE_STOP:   st_nxt.wd_en_o = !st_r.wd[scr_pkg::WD_STOP_DIS]
                                             || st_r.bus_started;
      default:              st_nxt.wd_en_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r    <= '0;
      st_r.ms <= scr_pkg::RST_MODE_SUPPLY;
      st_r.hw <= scr_pkg::RST_HW_CONTROL;
      st_r.wd <= scr_pkg::RST_WD_CONTROL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chip_mode                        = st_r.mode_o;
  assign second_supply_on                 = st_r.sup2_o;
  assign main_supply_overvoltage_reset_en = st_r.ms[scr_pkg::OVRST];
  assign main_supply_reset_threshold      = st_r.ms[scr_pkg::RT_HI:scr_pkg::RT_LO];
  assign failsafe_input_disable           = st_r.hw[scr_pkg::HW_FS_DIS];
  assign fail_outputs                     = st_r.fail_o;
  assign second_fail_output               = st_r.fail2_o;
  assign buck_pwm                         = st_r.pwm_o;
  assign boost_on                         = st_r.boost_o;
  assign boost_v_low                      = st_r.hw[scr_pkg::HW_BST_V];
  assign wd_enable                        = st_r.wd_en_o;
  assign wd_window_mode                   = st_r.wd[scr_pkg::WD_WINDOW];
  assign wd_long_window                   = st_r.long_win_o;
  assign wd_period                        = st_r.wd[scr_pkg::WD_PER_HI:scr_pkg::WD_PER_LO];
  assign wd_max3_reset                    = st_r.wd[scr_pkg::WD_MAX3];
  assign reset_out                        = st_r.rst_o;
  assign spi_fail                         = st_r.spi_fail_o;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_parity;
    ev && f.write && f.addr == scr_pkg::ADDR_WD_CONTROL && ^f.data && !restart_req
      && !overvoltage_evt |=> st_r.wd == $past(st_r.wd) && spi_fail;
  endproperty
  a_parity: assert property (p_parity) else $error("odd parity write altered wd");

  property p_soft;
    ev && f.write && f.addr == scr_pkg::ADDR_MODE_SUPPLY && f.data[7:6] == 2'b11
      |=> st_r.ms == 8'h00 && st_r.hw == 8'h00 && st_r.wd == 8'h14 && !reset_out;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset values wrong");

  property p_sleep;
    ev && f.write && f.addr == scr_pkg::ADDR_MODE_SUPPLY && f.data[7:6] == 2'b01
      && !wake_source_any |=> reset_out && st_r.ms[7:3] == 5'h00 ##1 !reset_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without wake not restarted");

  property p_rsvd;
    st_r.ms[5] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_ov;
    overvoltage_evt && main_supply_overvoltage_reset_en && !ev
      |=> reset_out && st_r.hw[5] == 1'b0 && st_r.wd[2:0] == 3'h4;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage restart missing");

  property p_force;
    st_r.hw[5] |=> fail_outputs;
  endproperty
  a_force: assert property (p_force) else $error("fail outputs not forced");

  property p_stop_wd;
    cur_mode == scr_pkg::MODE_STOP && st_r.wd[6] && !st_r.bus_started |=> !wd_enable;
  endproperty
  a_stop_wd: assert property (p_stop_wd) else $error("watchdog ran in stop");

  property p_buck_wk;
    cur_mode == scr_pkg::MODE_STOP && st_r.hw[4] && st_r.wake_lvl |=> buck_pwm [*2];
  endproperty
  a_buck_wk: assert property (p_buck_wk) else $error("wake pin did not select pwm");

  property p_read;
    ev && !f.write && f.addr == scr_pkg::ADDR_HW_CONTROL
      |=> st_r.resp == {$past(st_r.hw), 8'h00};
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_sup2_off;
    st_r.ms[4:3] == 2'b00 |=> !second_supply_on;
  endproperty
  a_sup2_off: assert property (p_sup2_off) else $error("second supply on while off");

  c_soft:   cover property (ev && f.write && f.addr == 7'h01 && f.data[7:6] == 2'b11);
  c_parity: cover property (ev && f.write && f.addr == 7'h03 && ^f.data);
  c_sleep:  cover property (reset_out ##1 !reset_out);
  c_bus:    cover property (wd_long_window);

endmodule // scr_spi_control_registers

/* verification/scr_host_model.sv */
`timescale 1ns/1ps
module scr_host_model (
  output logic      sclk,
  output logic      csn_n,
  output logic      mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sclk  = 1'b0;
    csn_n = 1'b1;
    mosi  = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Link clock runs only inside a frame, 125 ns per bit
  task automatic xfer(input scr_pkg::scr_frame_s f, output logic [15:0] rsp);
    logic [15:0] w;
    w = f;
    #3 csn_n = 1'b0;
    for (int k = 0; k < scr_pkg::FRAME_BITS; k++) begin
      mosi = w[k];
      #31.25 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      // Undriven line must never pass for data
      #31.25 rsp[k] = miso_oe ? miso_o : 1'bx;
    end
    #62.5 csn_n = 1'b1;
    // Released line shows the inverse, not a stale level
    mosi = ~mosi;
    #200;
  endtask
endmodule // scr_host_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk, rstn, sclk, csn_n, mosi, miso_o, miso_oe, wake_pin, wake_source_any;
  logic        overvoltage_evt, restart_req, bus_wake_evt, large_load, battery_low;
  logic        wd_fail_evt, spi_fail_clr, second_supply_on, main_supply_overvoltage_reset_en;
  logic        failsafe_input_disable, fail_outputs, second_fail_output, buck_pwm, boost_on;
  logic        boost_v_low, wd_enable, wd_window_mode, wd_long_window, wd_max3_reset;
  logic        reset_out, spi_fail;
  logic [1:0]  chip_mode, main_supply_reset_threshold;
  logic [2:0]  wd_period;
  logic [7:0]  d;
  logic [15:0] rsp;
  int          failures = 0;
  int          samples_checked = 0;
  int          pulses = 0;
  int          longw = 0;
  ////////////////////////////////////////////////////////////////////////////
  scr_spi_control_registers #(.LAG_SHORT(20), .LAG_LONG(50)) u_scr_spi_control_registers (
    .clk, .rstn, .sclk, .csn_n, .mosi, .miso_o, .miso_oe, .wake_pin, .wake_source_any,
    .overvoltage_evt, .restart_req, .bus_wake_evt, .large_load, .battery_low,
    .wd_fail_evt, .spi_fail_clr, .chip_mode, .second_supply_on,
    .main_supply_overvoltage_reset_en, .main_supply_reset_threshold,
    .failsafe_input_disable, .fail_outputs, .second_fail_output, .buck_pwm, .boost_on,
    .boost_v_low, .wd_enable, .wd_window_mode, .wd_long_window, .wd_period,
    .wd_max3_reset, .reset_out, .spi_fail);
  scr_host_model u_scr_host_model (.sclk, .csn_n, .mosi, .miso_o, .miso_oe);
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  // Single-cycle pulses are counted where they stand
  always @(posedge clk) begin
    if (reset_out === 1'b1) pulses <= pulses + 1;
    if (wd_long_window === 1'b1) longw <= longw + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Answer to a frame arrives in the following frame
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    u_scr_host_model.xfer(scr_pkg::scr_frame_s'{8'h00, 1'b0, a}, rsp);
    u_scr_host_model.xfer(scr_pkg::scr_frame_s'{8'h00, 1'b0, a}, rsp);
    v = rsp[15:8];
    @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    u_scr_host_model.xfer(scr_pkg::scr_frame_s'{v, 1'b1, a}, rsp);
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Top bit makes the byte sum even
  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    failures++;
    $display("ERROR t=%0t run did not finish", $time);
    wrap_up();
  end
  initial begin
    int p;
    clk = 1'b0;
    rstn = 1'b0;
    wake_pin = 1'b0;
    wake_source_any = 1'b1;
    overvoltage_evt = 1'b0;
    restart_req = 1'b0;
    bus_wake_evt = 1'b0;
    large_load = 1'b0;
    battery_low = 1'b0;
    wd_fail_evt = 1'b0;
    spi_fail_clr = 1'b0;
    tick(3);
    rstn <= 1'b1;
    tick(3);
    rdchk(7'h01, 8'h00);
    rdchk(7'h02, 8'h00);
    rdchk(7'h03, 8'h14);
    chk(wd_period, 3'b100);
    rdchk(7'h05, 8'h00);
    wr(7'h01, 8'h3f);
    rdchk(7'h01, 8'h1f);
    chk(main_supply_overvoltage_reset_en, 1'b1);
    $display("reset values and reserved bit done");
    for (int v = 0; v < 4; v++) begin
      wr(7'h01, {3'b000, v[1:0], 1'b0, v[1:0]});
      chk(second_supply_on, v != 0);
      chk(main_supply_reset_threshold, v[1:0]);
      wr(7'h01, {3'b100, v[1:0], 3'b000});
      chk(chip_mode, 2'b10);
      chk(second_supply_on, v >= 2);
      wr(7'h01, {3'b010, v[1:0], 3'b000});
      chk(chip_mode, 2'b01);
      chk(second_supply_on, v == 3);
    end
    $display("mode and supply fields done");
    battery_low <= 1'b1;
    wr(7'h02, 8'hff);
    rdchk(7'h02, 8'hff);
    chk({failsafe_input_disable, second_fail_output, fail_outputs}, 3'b111);
    chk({boost_v_low, boost_on}, 2'b11);
    battery_low <= 1'b0;
    tick(4);
    chk(boost_on, 1'b0);
    wr(7'h02, 8'h00);
    chk({failsafe_input_disable, second_fail_output, fail_outputs, boost_v_low}, 4'h0);
    $display("hardware control done");
    wr(7'h03, 8'h2a);
    rdchk(7'h03, 8'h14);
    chk(spi_fail, 1'b1);
    @(posedge clk) spi_fail_clr <= 1'b1;
    @(posedge clk) spi_fail_clr <= 1'b0;
    tick(3);
    chk(spi_fail, 1'b0);
    wr(7'h03, par(7'h2b));
    rdchk(7'h03, 8'h2b);
    chk({wd_window_mode, wd_max3_reset, wd_period}, 5'b11011);
    $display("watchdog parity done");
    wr(7'h02, 8'h3f);
    wr(7'h01, 8'h1f);
    p = pulses;
    @(posedge clk) restart_req <= 1'b1;
    @(posedge clk) restart_req <= 1'b0;
    tick(4);
    chk(pulses, p + 1);
    rdchk(7'h01, 8'h07);
    rdchk(7'h02, 8'h1f);
    rdchk(7'h03, 8'h0c);
    @(posedge clk) overvoltage_evt <= 1'b1;
    @(posedge clk) overvoltage_evt <= 1'b0;
    tick(4);
    chk(pulses, p + 2);
    wr(7'h01, 8'h03);
    @(posedge clk) overvoltage_evt <= 1'b1;
    @(posedge clk) overvoltage_evt <= 1'b0;
    tick(4);
    chk(pulses, p + 2);
    wake_source_any <= 1'b0;
    wr(7'h01, 8'h40);
    chk(pulses, p + 3);
    chk(chip_mode, 2'b00);
    wake_source_any <= 1'b1;
    wr(7'h02, 8'h01);
    wr(7'h01, 8'hc0);
    chk(pulses, p + 3);
    rdchk(7'h01, 8'h00);
    rdchk(7'h02, 8'h00);
    rdchk(7'h03, 8'h14);
    $display("restart and soft reset done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) wd_fail_evt <= 1'b1;
      @(posedge clk) wd_fail_evt <= 1'b0;
      tick(3);
      chk(fail_outputs, k[0]);
    end
    wr(7'h01, 8'hc0);
    wr(7'h02, 8'h01);
    @(posedge clk) wd_fail_evt <= 1'b1;
    @(posedge clk) wd_fail_evt <= 1'b0;
    tick(3);
    chk(fail_outputs, 1'b1);
    $display("fail output trigger done");
    // Small lag parameters keep these fixed waits short
    wr(7'h02, 8'h10);
    wr(7'h01, 8'h80);
    wake_pin <= 1'b1;
    tick(10);
    chk(buck_pwm, 1'b1);
    wake_pin <= 1'b0;
    tick(10);
    chk(buck_pwm, 1'b1);
    tick(30);
    chk(buck_pwm, 1'b0);
    wr(7'h02, 8'h50);
    wake_pin <= 1'b1;
    tick(10);
    wake_pin <= 1'b0;
    tick(40);
    chk(buck_pwm, 1'b1);
    tick(40);
    chk(buck_pwm, 1'b0);
    wr(7'h02, 8'h08);
    large_load <= 1'b1;
    tick(3);
    large_load <= 1'b0;
    tick(40);
    chk(buck_pwm, 1'b1);
    wr(7'h01, 8'h80);
    tick(40);
    chk(buck_pwm, 1'b0);
    $display("buck control done");
    chk(wd_enable, 1'b1);
    wr(7'h03, par(7'h44));
    chk(wd_enable, 1'b0);
    // First wake with bus start off, second with it on
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) bus_wake_evt <= 1'b1;
      @(posedge clk) bus_wake_evt <= 1'b0;
      tick(3);
      chk(longw, k);
      chk(wd_enable, k[0]);
      wr(7'h03, par(7'h54));
    end
    $display("watchdog stop control done");
    wrap_up();
  end
endmodule // tb_top
